// ---- dv/scp_sva.sv ----
// assertions on the serial pins and sync outputs of the port
// assumes bind onto serial_config_port, one core clock
`default_nettype none
module scp_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic hwReset_n,
    input wire logic clkEn,
    input wire logic sleep_request_n,
    // serial pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic readbackOutputPin,
    input wire logic readbackOe,
    // status
    input wire logic sleepActive,
    input wire logic distPowerDown,
    input wire logic outputSyncPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rstAny;
    logic rstSeen_r;
    assign rstAny = sys_rst | ~hwReset_n;
    // ==========
    // first edge after any reset
    always_ff @(posedge core_clk or posedge rstAny) begin
        if (rstAny) rstSeen_r <= 1'b1;
        else rstSeen_r <= 1'b0;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rstAny);
    sequence sRise;
        $rose(sclk) && sdioOe;
    endsequence
    sequence sRbRise;
        $rose(sclk) && readbackOe;
    endsequence
    // ==========
    // checks
    AST_IDLE_HIZ: assert property (csN [*3] |-> !sdioOe && !readbackOe)
        else $error("pins driven while deselected");
    AST_ONE_PIN: assert property (!(sdioOe && readbackOe))
        else $error("both read pins driven");
    AST_LAUNCH_LOW: assert property ($changed(sdioOut) && sdioOe |-> !sclk)
        else $error("read bit launched while shift clock high");
    AST_HOLD_HIGH: assert property (sRise |=> $stable(sdioOut) [*3])
        else $error("shared pin moved while shift clock high");
    AST_RB_HOLD: assert property (sRbRise |=> $stable(readbackOutputPin) [*3])
        else $error("readback pin moved while shift clock high");
    AST_OE_START: assert property ($rose(sdioOe) |-> !csN)
        else $error("shared pin driven outside a frame");
    AST_POR_SYNC: assert property (rstSeen_r && clkEn |=> outputSyncPulse)
        else $error("no sync after reset");
    AST_SYNC_ONE: assert property (outputSyncPulse |=> !outputSyncPulse)
        else $error("sync pulse longer than one cycle");
    AST_SLEEP: assert property (!sleep_request_n [*3] |-> sleepActive && distPowerDown)
        else $error("sleep not applied");
endmodule
bind serial_config_port scp_sva scp_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst), .hwReset_n(hwReset_n),
    .clkEn(clkEn), .sleep_request_n(sleep_request_n), .sclk(sclk), .csN(csN), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .readbackOutputPin(readbackOutputPin), .readbackOe(readbackOe),
    .sleepActive(sleepActive), .distPowerDown(distPowerDown), .outputSyncPulse(outputSyncPulse));
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// host side of the serial link: shift clock, select and write data
// assumes core_clk from the bench, four core cycles per clock phase
`default_nettype none
module spi_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic sclk,
    output logic csN,
    output logic mosi,
    output logic hostOe,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0; // clock stands still outside frames
        csN = 1'b1;
        mosi = 1'b0;
        hostOe = 1'b1;
    end
    // ==========
    // one bit; read bit taken just before the rise
    task automatic bitx(input logic b, input logic rel, output logic r);
        mosi <= b;
        repeat (4) @(posedge core_clk);
        r = miso;
        sclk <= 1'b1;
        if (rel) hostOe <= 1'b0;
        repeat (4) @(posedge core_clk);
        sclk <= 1'b0;
    endtask
    task automatic pause();
        csN <= 1'b1;
        repeat (8) @(posedge core_clk);
        csN <= 1'b0;
    endtask
    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr, input int nb,
        input logic lsb, input logic stall, ref logic [7:0] dat[$]);
        logic [15:0] ins;
        logic [7:0] b;
        logic r;
        ins = {rd, len, addr};
        csN <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            bitx(ins[lsb ? i : 15 - i], rd && i == 15, r);
            if (stall && i % 8 == 7) pause();
        end
        for (int k = 0; k < nb; k++) begin
            for (int i = 0; i < 8; i++) begin
                // released line shows a changing pattern
                bitx(rd ? ~mosi : dat[k][lsb ? i : 7 - i], 1'b0, r);
                b[lsb ? i : 7 - i] = r;
            end
            if (rd) dat.push_back(b);
            if (stall && k < nb - 1) pause();
        end
        repeat (4) @(posedge core_clk);
        csN <= 1'b1;
        hostOe <= 1'b1;
        // select must be seen high before the next frame
        repeat (4) @(posedge core_clk);
    endtask
    task automatic abortMid();
        logic r;
        csN <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            bitx(1'b0, 1'b0, r);
            if (i == 7) pause();
        end
        csN <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_serial_config_port.sv ----
// self-checking bench for the serial configuration port
// assumes design, checker and host model compile first
`include "serial_config_port_regs.vh"
`default_nettype none
module tb_serial_config_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, hwReset_n, sleep_request_n, chargePumpEvent;
    logic sclk, csN, mosi, hostOe, sdioOut, sdioOe, readbackOutputPin, readbackOe;
    logic pllPowerDown, distPowerDown, sleepActive, outputSyncPulse, rbSel, lsbM;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] shadowM [0:562];
    logic [7:0] activeM [0:562];
    wire sdioWire;
    wire miso;
    int miscompares, check_count;
    assign sdioWire = sdioOe ? sdioOut : mosi;
    assign miso = rbSel ? (readbackOe ? readbackOutputPin : ~mosi) : sdioWire;
    serial_config_port serial_config_port_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
        .hwReset_n(hwReset_n), .sleep_request_n(sleep_request_n), .sclk(sclk), .csN(csN), .sdioIn(sdioWire),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .readbackOutputPin(readbackOutputPin), .readbackOe(readbackOe),
        .chargePumpEvent(chargePumpEvent), .pllPowerDown(pllPowerDown), .distPowerDown(distPowerDown),
        .sleepActive(sleepActive), .outputSyncPulse(outputSyncPulse), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    spi_host_model spi_host_model_inst (.core_clk(core_clk), .sclk(sclk), .csN(csN), .mosi(mosi),
        .hostOe(hostOe), .miso(miso));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        chargePumpEvent <= 1'($urandom);
        if (sdioOe === 1'b1) chk("host released", 32'(hostOe), 32'h0);
    end
    // ==========
    // tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic peek(input logic [9:0] a);
        logic [31:0] d;
        logic e;
        apb(1'b1, `APB_PEEK_ADDR, {22'h0, a}, d, e);
        apb(1'b0, `APB_PEEK_DATA, 32'h0, d, e);
        chk("active byte", d, 32'(activeM[a]));
    endtask
    task automatic resetModel();
        for (int i = 0; i < 563; i++) begin
            shadowM[i] = 8'h00;
            activeM[i] = 8'h00;
        end
        shadowM[0] = 8'h18;
        activeM[0] = 8'h18;
        lsbM = 1'b0;
        rbSel = 1'b0;
    endtask
    task automatic modelWrite(input logic [9:0] a, input logic [7:0] d);
        if (a == 10'h000) begin
            if (d[5] && d[2]) resetModel();
            shadowM[0] = d;
            activeM[0] = d;
            lsbM = d[6];
            rbSel = d[7];
        end else if (a == 10'h232) begin
            if (d[0]) for (int i = 0; i < 562; i++) activeM[i] = shadowM[i];
        end else if (a < 10'h232) shadowM[a] = d;
    endtask
    function automatic logic [7:0] expRead(input logic [9:0] a);
        if (a >= 10'h232) return 8'h00;
        return activeM[4][0] ? activeM[a] : shadowM[a];
    endfunction
    task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] addr, input int nb,
        input logic stall, input logic [7:0] wq[$]);
        logic [7:0] q[$];
        logic [9:0] a;
        q = wq;
        a = addr;
        spi_host_model_inst.frame(rd, len, {3'h0, addr}, nb, lsbM, stall, q);
        for (int k = 0; k < nb; k++) begin
            if (rd) chk("serial read", 32'(q[k]), 32'(expRead(a)));
            else modelWrite(a, q[k]);
            a = lsbM ? a + 10'h1 : (a == 10'h000 ? 10'h232 : a - 10'h1);
        end
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
    // ==========
    // main sequence
    initial begin
        logic [31:0] d;
        logic e;
        logic [7:0] none[$];
        void'($urandom(12819));
        {sys_rst, hwReset_n, sleep_request_n, chargePumpEvent} = 4'b1110;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        resetModel();
        miscompares = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `APB_CTRL, 32'h0, d, e);
        chk("ctrl default", d, 32'h1);
        apb(1'b0, 12'h100, 32'h0, d, e);
        chk("unmapped error", 32'(e), 32'h1);
        // staged writes with stalls, shadow read back
        xfer(1'b0, `SCP_LEN_THREE, 10'h012, 3, 1'b1, {8'($urandom), 8'($urandom), 8'($urandom)});
        peek(10'h011);
        xfer(1'b1, `SCP_LEN_TWO, 10'h012, 2, 1'b1, none);
        // msb-first stream wraps to the update byte and stops
        xfer(1'b0, `SCP_LEN_STREAM, 10'h001, 3, 1'b0, {8'($urandom), 8'h18, 8'h01});
        peek(10'h010);
        // reads from active registers
        xfer(1'b0, `SCP_LEN_ONE, 10'h004, 1, 1'b0, {8'h01});
        xfer(1'b0, `SCP_LEN_ONE, 10'h232, 1, 1'b0, {8'h01});
        xfer(1'b0, `SCP_LEN_ONE, 10'h011, 1, 1'b0, {8'($urandom)});
        xfer(1'b1, `SCP_LEN_ONE, 10'h011, 1, 1'b0, none);
        // power-down controls
        xfer(1'b0, `SCP_LEN_ONE, 10'h010, 1, 1'b0, {8'h01});
        xfer(1'b0, `SCP_LEN_ONE, 10'h230, 1, 1'b0, {8'h02});
        xfer(1'b0, `SCP_LEN_ONE, 10'h232, 1, 1'b0, {8'h01});
        chk("pll down", 32'(pllPowerDown), 32'h1);
        chk("dist down", 32'(distPowerDown), 32'h1);
        // lsb-first stream on the readback pin
        xfer(1'b0, `SCP_LEN_ONE, 10'h000, 1, 1'b0, {8'hDB});
        xfer(1'b1, `SCP_LEN_STREAM, 10'h230, 3, 1'b0, none);
        xfer(1'b0, `SCP_LEN_ONE, 10'h000, 1, 1'b0, {8'h18});
        // mid-byte select rise
        spi_host_model_inst.abortMid();
        apb(1'b0, `APB_STATUS, 32'h0, d, e);
        chk("abort count", 32'(d[9:2]), 32'h1);
        xfer(1'b1, `SCP_LEN_ONE, 10'h010, 1, 1'b0, none);
        // soft reset held then released
        xfer(1'b0, `SCP_LEN_ONE, 10'h000, 1, 1'b0, {8'h3C});
        peek(10'h010);
        xfer(1'b0, `SCP_LEN_ONE, 10'h000, 1, 1'b0, {8'h18});
        // port stays alive in sleep
        sleep_request_n <= 1'b0;
        xfer(1'b0, `SCP_LEN_TWO, 10'h011, 2, 1'b0, {8'($urandom), 8'h03});
        xfer(1'b0, `SCP_LEN_ONE, 10'h232, 1, 1'b0, {8'h01});
        sleep_request_n <= 1'b1;
        peek(10'h011);
        chk("pll sync down", 32'(pllPowerDown), 32'h1);
        // hardware reset pin
        hwReset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        hwReset_n <= 1'b1;
        resetModel();
        peek(10'h011);
        close_out();
    end
endmodule
`default_nettype wire

// ---- verilog/apb_ctrl_regs.v ----
// apb slave holding port enable, status and a peek window into the active registers
// assumes a single core clock and a master that waits while pready is low
`include "serial_config_port_regs.vh"
`default_nettype none

module apb_ctrl_regs (
    // clock and reset
    input wire core_clk,
    input wire rstAny,
    input wire clkEn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // block side
    output reg portEnable_r,
    output reg [9:0] peekAddr_r,
    input wire busy,
    input wire stalled,
    input wire [7:0] abortCnt,
    input wire [7:0] peekData
);

// ==========================================
// decode
wire mapped = (paddr == `APB_CTRL) | (paddr == `APB_STATUS) |
              (paddr == `APB_PEEK_ADDR) | (paddr == `APB_PEEK_DATA);
wire access = psel & penable & clkEn;

// frozen state cannot answer, so the access stretches while the enable is low
assign pready = clkEn;
assign pslverr = psel & penable & ~mapped;

always @* begin
    case (paddr)
        `APB_CTRL: prdata = {31'h0, portEnable_r};
        `APB_STATUS: prdata = {22'h0, abortCnt, stalled, busy};
        `APB_PEEK_ADDR: prdata = {22'h0, peekAddr_r};
        `APB_PEEK_DATA: prdata = {24'h0, peekData};
        default: prdata = 32'h0;
    endcase
end

// ==========================================
// writes
always @(posedge core_clk or posedge rstAny) begin
    if (rstAny) begin
        portEnable_r <= `APB_CTRL_DEFAULT;
        peekAddr_r <= 10'h000;
    end else if (access & pwrite) begin
        if (paddr == `APB_CTRL)
            portEnable_r <= pwdata[0];
        if (paddr == `APB_PEEK_ADDR)
            peekAddr_r <= pwdata[9:0];
    end
end

endmodule

`default_nettype wire

// ---- verilog/serial_config_port.v ----
// serial configuration port with shadow and active register space
// assumes shift clock, select and data pins already synchronous to core_clk
`include "serial_config_port_regs.vh"
`default_nettype none

module serial_config_port (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    input wire clkEn,
    input wire hwReset_n,
    input wire sleep_request_n,
    // serial pins
    input wire sclk,
    input wire csN,
    input wire sdioIn,
    output reg sdioOut,
    output wire sdioOe,
    output reg readbackOutputPin,
    output wire readbackOe,
    // analog control
    input wire chargePumpEvent,
    output reg pllPowerDown,
    output reg distPowerDown,
    output reg sleepActive,
    output reg outputSyncPulse,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr
);

// ==========================================
// states
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_INSTR = 4'h2;
localparam [3:0] ST_DATA = 4'h4;
localparam [3:0] ST_STALL = 4'h8;

// ==========================================
// storage
reg [7:0] shadowMem [0:`SCP_MEM_DEPTH-1];
reg [7:0] activeMem [0:`SCP_MEM_DEPTH-1];
integer i;

reg [3:0] state_r;
reg stallInInstr_r;
reg sclk_r;
reg cs_r;
reg sleep_r;
reg [3:0] cnt_r;
reg [15:0] instrSr_r;
reg [7:0] dataSr_r;
reg [7:0] outSr_r;
reg isRead_r;
reg stream_r;
reg [1:0] bytesLeft_r;
reg [9:0] curAddr_r;
reg softRst_r;
reg syncPend_r;
reg [7:0] abortCnt_r;
reg distPdQ_r;

wire portEnable;
wire [9:0] peekAddr;

// hardware reset pin acts without the clock
wire rstAny = sys_rst | ~hwReset_n;

// ==========================================
// pin edges
wire sclkRise = sclk & ~sclk_r & ~csN;
wire sclkFall = ~sclk & sclk_r & ~csN;
wire csFall = ~csN & cs_r;
wire csRise = csN & ~cs_r;

// port config takes effect at once, not through the update
wire [7:0] portCfg = activeMem[`SCP_ADDR_PORTCFG];
wire lsbFirst = portCfg[`SCP_BIT_LSB_FIRST];
wire rbPinSel = portCfg[`SCP_BIT_RB_PIN];
wire readActive = activeMem[`SCP_ADDR_READSEL][`SCP_BIT_READ_ACTIVE];
wire [1:0] pllMode = activeMem[`SCP_ADDR_PLLPD][1:0];
wire distPdBit = activeMem[`SCP_ADDR_DISTPD][`SCP_BIT_DIST_PD];

// ==========================================
// shifters
wire [15:0] instrNxt = lsbFirst ? {sdioIn, instrSr_r[15:1]} : {instrSr_r[14:0], sdioIn};
wire [7:0] dataNxt = lsbFirst ? {sdioIn, dataSr_r[7:1]} : {dataSr_r[6:0], sdioIn};
// bit due on the pin for the current count
wire launchBit = lsbFirst ? outSr_r[cnt_r[2:0]] : outSr_r[`SCP_BYTE_LAST - cnt_r[2:0]];

wire decRead = instrNxt[`SCP_INSTR_RW];
wire [1:0] decLen = instrNxt[`SCP_INSTR_LEN_HI:`SCP_INSTR_LEN_LO];
wire [9:0] decAddr = instrNxt[`SCP_INSTR_ADDR_HI:0];

// next address after a byte
wire [9:0] stepAddr = lsbFirst ? curAddr_r + 10'h001 :
                      ((curAddr_r == 10'h000) ? `SCP_ADDR_TOP : curAddr_r - 10'h001);
wire lastByte = stream_r ? (curAddr_r == `SCP_ADDR_TOP) : (bytesLeft_r == 2'h0);

// read source, shadow or active
wire [9:0] loadAddr = (state_r == ST_INSTR) ? decAddr : stepAddr;
wire loadOk = loadAddr <= `SCP_ADDR_TOP;
wire [7:0] loadByte = ~loadOk ? `SCP_REG_DEFAULT :
                      (readActive ? activeMem[loadAddr] : shadowMem[loadAddr]);
wire [7:0] peekData = (peekAddr <= `SCP_ADDR_TOP) ? activeMem[peekAddr] : 8'h00;

wire readPhase = (state_r == ST_DATA) & isRead_r & ~csN;
assign sdioOe = readPhase & ~rbPinSel;
assign readbackOe = readPhase & rbPinSel;

// ==========================================
// serial engine and register space
always @(posedge core_clk or posedge rstAny) begin
    if (rstAny) begin
        state_r <= ST_IDLE;
        stallInInstr_r <= 1'b0;
        sclk_r <= 1'b0;
        cs_r <= 1'b1;
        sleep_r <= 1'b1;
        cnt_r <= 4'h0;
        instrSr_r <= 16'h0000;
        dataSr_r <= 8'h00;
        outSr_r <= 8'h00;
        isRead_r <= 1'b0;
        stream_r <= 1'b0;
        bytesLeft_r <= 2'h0;
        curAddr_r <= 10'h000;
        softRst_r <= 1'b0;
        syncPend_r <= 1'b1;
        abortCnt_r <= 8'h00;
        sdioOut <= 1'b0;
        readbackOutputPin <= 1'b0;
        outputSyncPulse <= 1'b0;
        for (i = 0; i < `SCP_MEM_DEPTH; i = i + 1) begin
            shadowMem[i] <= `SCP_REG_DEFAULT;
            activeMem[i] <= `SCP_REG_DEFAULT;
        end
        shadowMem[`SCP_ADDR_PORTCFG] <= `SCP_PORTCFG_DEFAULT;
        activeMem[`SCP_ADDR_PORTCFG] <= `SCP_PORTCFG_DEFAULT;
    end else if (clkEn) begin
        sclk_r <= sclk;
        cs_r <= csN;
        sleep_r <= sleep_request_n;
        outputSyncPulse <= syncPend_r;
        syncPend_r <= 1'b0;
        if (sleep_request_n & ~sleep_r)
            syncPend_r <= 1'b1;
        if (~distPdBit & distPdQ_r)
            syncPend_r <= 1'b1;
        // soft reset holds everything but the port config at default
        if (softRst_r) begin
            for (i = 1; i < `SCP_MEM_DEPTH; i = i + 1) begin
                shadowMem[i] <= `SCP_REG_DEFAULT;
                activeMem[i] <= `SCP_REG_DEFAULT;
            end
        end
        case (state_r)
            ST_IDLE: begin
                // serial port stays live regardless of sleep
                if (csFall & portEnable) begin
                    state_r <= ST_INSTR;
                    cnt_r <= 4'h0;
                end
            end
            ST_INSTR: begin
                if (csRise) begin
                    if (cnt_r[2:0] != 3'h0) begin
                        state_r <= ST_IDLE;
                        abortCnt_r <= abortCnt_r + 8'h01;
                    end else begin
                        state_r <= ST_STALL;
                        stallInInstr_r <= 1'b1;
                    end
                end else if (sclkRise) begin
                    instrSr_r <= instrNxt;
                    if (cnt_r == `SCP_INSTR_LAST) begin
                        state_r <= ST_DATA;
                        cnt_r <= 4'h0;
                        isRead_r <= decRead;
                        stream_r <= (decLen == `SCP_LEN_STREAM);
                        // remaining bytes after the current one
                        case (decLen)
                            `SCP_LEN_ONE: bytesLeft_r <= 2'h0;
                            `SCP_LEN_TWO: bytesLeft_r <= 2'h1;
                            `SCP_LEN_THREE: bytesLeft_r <= 2'h2;
                            default: bytesLeft_r <= 2'h0;
                        endcase
                        curAddr_r <= decAddr;
                        outSr_r <= loadByte;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
            end
            ST_DATA: begin
                if (csRise) begin
                    if (cnt_r[2:0] != 3'h0) begin
                        state_r <= ST_IDLE;
                        abortCnt_r <= abortCnt_r + 8'h01;
                    end else if (stream_r) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_STALL;
                        stallInInstr_r <= 1'b0;
                    end
                end else begin
                    if (sclkFall & isRead_r) begin
                        // bit index follows rises seen in this byte
                        if (rbPinSel)
                            readbackOutputPin <= launchBit;
                        else
                            sdioOut <= launchBit;
                    end
                    if (sclkRise) begin
                        dataSr_r <= dataNxt;
                        if (cnt_r[2:0] == `SCP_BYTE_LAST) begin
                            cnt_r <= 4'h0;
                            if (~isRead_r) begin
                                if (curAddr_r == `SCP_ADDR_TOP) begin
                                    // update is self-clearing: the top byte never stores
                                    if (dataNxt[`SCP_BIT_UPDATE]) begin
                                        for (i = 0; i < `SCP_MEM_DEPTH - 1; i = i + 1)
                                            activeMem[i] <= shadowMem[i];
                                    end
                                end else if (curAddr_r == `SCP_ADDR_PORTCFG) begin
                                    shadowMem[`SCP_ADDR_PORTCFG] <= dataNxt;
                                    activeMem[`SCP_ADDR_PORTCFG] <= dataNxt;
                                    softRst_r <= dataNxt[`SCP_BIT_SOFTRST_HI] &
                                                 dataNxt[`SCP_BIT_SOFTRST_LO];
                                    if (softRst_r & ~(dataNxt[`SCP_BIT_SOFTRST_HI] &
                                                      dataNxt[`SCP_BIT_SOFTRST_LO]))
                                        syncPend_r <= 1'b1;
                                end else if (curAddr_r < `SCP_ADDR_TOP) begin
                                    // reserved and blank bytes are kept too
                                    shadowMem[curAddr_r] <= dataNxt;
                                end
                            end
                            if (lastByte) begin
                                state_r <= ST_IDLE;
                            end else begin
                                curAddr_r <= stepAddr;
                                bytesLeft_r <= bytesLeft_r - 2'h1;
                                outSr_r <= loadByte;
                            end
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
            end
            ST_STALL: begin
                // a short low pulse then a mid-byte rise ends the transfer
                if (csFall) begin
                    state_r <= stallInInstr_r ? ST_INSTR : ST_DATA;
                    // the launching fall came with the select rise, so the bit is driven again here
                    if (~stallInInstr_r & isRead_r) begin
                        if (rbPinSel)
                            readbackOutputPin <= launchBit;
                        else
                            sdioOut <= launchBit;
                    end
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// ==========================================
// power control
always @(posedge core_clk or posedge rstAny) begin
    if (rstAny) begin
        pllPowerDown <= 1'b0;
        distPowerDown <= 1'b0;
        sleepActive <= 1'b0;
        distPdQ_r <= 1'b0;
    end else if (clkEn) begin
        sleepActive <= ~sleep_request_n;
        distPdQ_r <= distPdBit;
        distPowerDown <= distPdBit | ~sleep_request_n;
        // sync mode waits for the pump so the loop sees no frequency step
        if (pllMode == `SCP_PLL_ASYNC)
            pllPowerDown <= 1'b1;
        else if (pllMode == `SCP_PLL_SYNC) begin
            if (chargePumpEvent)
                pllPowerDown <= 1'b1;
        end else
            pllPowerDown <= ~sleep_request_n;
    end
end

// ==========================================
// apb control
apb_ctrl_regs ctrlRegs (
    .core_clk(core_clk),
    .rstAny(rstAny),
    .clkEn(clkEn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .portEnable_r(portEnable),
    .peekAddr_r(peekAddr),
    .busy(state_r != ST_IDLE),
    .stalled(state_r == ST_STALL),
    .abortCnt(abortCnt_r),
    .peekData(peekData)
);

endmodule

`default_nettype wire

// ---- verilog/serial_config_port_regs.vh ----
// constants of the serial configuration port and its apb control registers
// assumes inclusion by bare name from the design files
`ifndef SERIAL_CONFIG_PORT_REGS_VH
`define SERIAL_CONFIG_PORT_REGS_VH

// ==========================================
// configuration space
`define SCP_ADDR_PORTCFG 10'h000
`define SCP_ADDR_READSEL 10'h004
`define SCP_ADDR_PLLPD 10'h010
`define SCP_ADDR_DISTPD 10'h230
`define SCP_ADDR_TOP 10'h232
`define SCP_MEM_DEPTH 563
`define SCP_PORTCFG_DEFAULT 8'h18
`define SCP_REG_DEFAULT 8'h00

// ==========================================
// field positions
`define SCP_BIT_RB_PIN 7
`define SCP_BIT_LSB_FIRST 6
`define SCP_BIT_SOFTRST_HI 5
`define SCP_BIT_SOFTRST_LO 2
`define SCP_BIT_READ_ACTIVE 0
`define SCP_BIT_UPDATE 0
`define SCP_BIT_DIST_PD 1

// ==========================================
// instruction word
`define SCP_INSTR_RW 15
`define SCP_INSTR_LEN_HI 14
`define SCP_INSTR_LEN_LO 13
`define SCP_INSTR_ADDR_HI 9
`define SCP_INSTR_LAST 4'hF
`define SCP_BYTE_LAST 3'h7
`define SCP_LEN_ONE 2'h0
`define SCP_LEN_TWO 2'h1
`define SCP_LEN_THREE 2'h2
`define SCP_LEN_STREAM 2'h3
`define SCP_PLL_ASYNC 2'h1
`define SCP_PLL_SYNC 2'h3

// ==========================================
// apb control registers
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define APB_PEEK_ADDR 12'h008
`define APB_PEEK_DATA 12'h00C
`define APB_CTRL_DEFAULT 1'h1

`endif
